// file: src/sep_read_path.sv
// Functional notes
// - direction bit one in the device address byte selects a read.
// - word counter holds last accessed location plus one; after a write it wraps within the page.
// - counter survives Start and Stop; only power-up reset clears it.
// - read increment past the last array byte wraps to location zero.
// - current-address read: ack address byte, then shift out byte at counter.
// - master no-ack on ninth clock ends the read; release line, go idle.
// - upper address bits of a read address byte are ignored.
// - after the repeated-start read byte, ack and send byte at loaded address.
// - sequential read follows either read kind; master acks for more.
// - each master ack increments the counter and sends the next byte.
// - sequential read wraps at the array top without a break.
// - every array byte starts as all ones.
// - address byte: type in bits 7-4, upper address in 3-1, direction in 0.
// - word address byte gives low eight address bits, msb first.
// - type mismatch: no ack, back to idle.
`timescale 1ns/1ns
`default_nettype none
module sep_read_path (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // two-wire link
  input  wire logic scl,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe
);
  import sep_pkg::*;

  // ----------------------------------------------------------------
  // pin sampling and bus conditions
  // ----------------------------------------------------------------
  logic scl_s1;
  logic scl_s2;
  logic scl_q;
  logic sda_s1;
  logic sda_s2;
  logic sda_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_q  <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_q  <= 1'b1;
    end else begin
      scl_s1 <= scl;
      scl_s2 <= scl_s1;
      scl_q  <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_q  <= sda_s2;
    end
  end

  logic rise;
  logic fall;
  logic start_c;
  logic stop_c;

  assign rise    = scl_s2 && !scl_q;
  assign fall    = !scl_s2 && scl_q;
  assign start_c = scl_s2 && scl_q && sda_q && !sda_s2;
  assign stop_c  = scl_s2 && scl_q && !sda_q && sda_s2;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  sep_state_e  state;
  logic [3:0]  bit_cnt;
  logic [7:0]  rx;
  logic [7:0]  tx;
  logic [2:0]  upper_addr;
  logic        master_ack;
  logic [10:0] word_addr;
  logic        fetch_pend;
  // erased contents as a declaration value, so the write process stays the only driver
  logic [7:0]  mem [DEPTH] = '{default: ERASED};

  logic        byte_done;
  logic        ack_slot;
  logic        type_ok;
  logic        rd_sel;
  logic        ev_waddr;
  logic        ev_wdata;
  logic        fetch_set;
  logic        buf_in_ready;
  logic        buf_out_valid;
  logic        buf_pop;
  logic        push;
  sep_word_s   fetch_word;
  sep_word_s   buf_word;

  assign byte_done = fall && (bit_cnt == BYTE_BITS);
  assign ack_slot  = (state == SEP_DEV_ACK) || (state == SEP_WADDR_ACK) ||
                     (state == SEP_RD_ACK);
  assign type_ok   = (rx[7:TYPE_LSB] == DEV_TYPE);
  assign rd_sel    = (rx[DIR_BIT] == DIR_READ);
  assign ev_waddr  = byte_done && (state == SEP_WADDR);
  assign ev_wdata  = byte_done && (state == SEP_WDATA);
  assign fetch_set = (byte_done && (state == SEP_DEV) && type_ok && rd_sel) ||
                     (rise && (state == SEP_RD_ACK) && !sda_s2);
  assign push      = fetch_pend && buf_in_ready;
  assign buf_pop   = fall && buf_out_valid &&
                     (((state == SEP_DEV_ACK) && (rx[DIR_BIT] == DIR_READ)) ||
                      ((state == SEP_RD_ACK) && master_ack));
  assign fetch_word = '{addr: word_addr, data: mem[word_addr]};

  // ----------------------------------------------------------------
  // array writes
  // ----------------------------------------------------------------
  // writes land at once; the self-timed cycle is not modelled
  always_ff @(posedge mclk) begin
    if (ev_wdata) begin
      mem[word_addr] <= rx;
    end
  end

  // ----------------------------------------------------------------
  // word address counter
  // ----------------------------------------------------------------
  // bus conditions never touch it, only rst_n at power-up
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      word_addr <= ADDR_RST;
    end else if (ev_waddr) begin
      word_addr <= {upper_addr, rx};
    end else if (ev_wdata) begin
      word_addr <= sep_page_inc(word_addr);
    end else if (push) begin
      word_addr <= sep_seq_inc(word_addr);
    end
  end

  // ----------------------------------------------------------------
  // fetch on demand
  // ----------------------------------------------------------------
  // no prefetch: the counter must not run ahead of the master
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_pend <= 1'b0;
    end else if (fetch_set) begin
      fetch_pend <= 1'b1;
    end else if (push) begin
      fetch_pend <= 1'b0;
    end
  end

  sep_buf u_buf (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_valid  (fetch_pend),
    .in_ready  (buf_in_ready),
    .in_word   (fetch_word),
    .out_valid (buf_out_valid),
    .out_ready (buf_pop),
    .out_word  (buf_word)
  );

  // ----------------------------------------------------------------
  // receive shifter and bit counter
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx      <= 8'h00;
      bit_cnt <= CNT_ZERO;
    end else if (start_c) begin
      bit_cnt <= CNT_ZERO;
    end else if (rise && !ack_slot) begin
      // the ninth bit is neither shifted in nor counted: direction bit must survive
      rx      <= {rx[6:0], sda_s2};
      bit_cnt <= bit_cnt + CNT_ONE;
    end else if (fall && (bit_cnt == BYTE_BITS)) begin
      bit_cnt <= CNT_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // protocol state and line drive
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= SEP_IDLE;
      sda_oe     <= 1'b0;
      sda_out    <= 1'b0;
      tx         <= 8'h00;
      upper_addr <= 3'h0;
      master_ack <= 1'b0;
    end else if (start_c) begin
      state  <= SEP_DEV;
      sda_oe <= 1'b0;
    end else if (stop_c) begin
      state  <= SEP_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        SEP_IDLE: begin
          sda_oe <= 1'b0;
        end
        SEP_DEV: begin
          if (byte_done) begin
            if (type_ok) begin
              sda_oe <= 1'b1;
              state  <= SEP_DEV_ACK;
              if (!rd_sel) begin
                upper_addr <= rx[UPPER_MSB:UPPER_LSB];
              end
            end else begin
              state <= SEP_IDLE;
            end
          end
        end
        SEP_DEV_ACK: begin
          if (fall) begin
            if (rx[DIR_BIT] == DIR_READ) begin
              // upper bits of a read address byte play no part
              tx     <= buf_word.data;
              sda_oe <= ~buf_word.data[7];
              state  <= SEP_RD;
            end else begin
              sda_oe <= 1'b0;
              state  <= SEP_WADDR;
            end
          end
        end
        SEP_WADDR, SEP_WDATA: begin
          if (byte_done) begin
            sda_oe <= 1'b1;
            state  <= SEP_WADDR_ACK;
          end
        end
        SEP_WADDR_ACK: begin
          if (fall) begin
            sda_oe <= 1'b0;
            state  <= SEP_WDATA;
          end
        end
        SEP_RD: begin
          if (byte_done) begin
            sda_oe     <= 1'b0;
            master_ack <= 1'b0;
            state      <= SEP_RD_ACK;
          end else if (fall) begin
            tx     <= {tx[6:0], 1'b0};
            sda_oe <= ~tx[6];
          end
        end
        SEP_RD_ACK: begin
          if (rise) begin
            if (sda_s2) begin
              state <= SEP_IDLE;
            end else begin
              master_ack <= 1'b1;
            end
          end else if (fall && master_ack) begin
            tx     <= buf_word.data;
            sda_oe <= ~buf_word.data[7];
            state  <= SEP_RD;
          end
        end
        default: begin
          state  <= SEP_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: src/sep_pkg.sv
package sep_pkg;
  // ----------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------
  localparam int          ADDR_W     = 11;
  localparam int          DEPTH      = 2048;
  localparam int          PAGE_W     = 4;
  localparam logic [7:0]  ERASED     = 8'hff;
  localparam logic [10:0] ADDR_RST   = 11'h000;

  // ----------------------------------------------------------------
  // device address byte layout
  // ----------------------------------------------------------------
  // type identifier value is arbitrary
  localparam logic [3:0]  DEV_TYPE   = 4'h5;
  localparam int          TYPE_LSB   = 4;
  localparam int          UPPER_LSB  = 1;
  localparam int          UPPER_MSB  = 3;
  localparam int          DIR_BIT    = 0;
  localparam logic        DIR_READ   = 1'b1;

  // ----------------------------------------------------------------
  // bit timing
  // ----------------------------------------------------------------
  localparam logic [3:0]  BYTE_BITS  = 4'h8;
  localparam logic [3:0]  CNT_ZERO   = 4'h0;
  localparam logic [3:0]  CNT_ONE    = 4'h1;

  typedef enum logic [3:0] {
    SEP_IDLE,
    SEP_DEV,
    SEP_DEV_ACK,
    SEP_WADDR,
    SEP_WADDR_ACK,
    SEP_WDATA,
    SEP_RD,
    SEP_RD_ACK
  } sep_state_e;

  typedef struct packed {
    logic [10:0] addr;
    logic [7:0]  data;
  } sep_word_s;

  // wraps from the top of the array to location zero
  function automatic logic [10:0] sep_seq_inc(input logic [10:0] a);
    sep_seq_inc = a + 11'h001;
  endfunction

  // write data stays inside its page
  function automatic logic [10:0] sep_page_inc(input logic [10:0] a);
    sep_page_inc = {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + 4'h1};
  endfunction
endpackage

// file: src/sep_buf.sv
`timescale 1ns/1ns
`default_nettype none
module sep_buf (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // fill side
  input  wire logic              in_valid,
  output logic                   in_ready,
  input  wire sep_pkg::sep_word_s in_word,
  // drain side
  output logic                   out_valid,
  input  wire logic              out_ready,
  output sep_pkg::sep_word_s     out_word
);
  import sep_pkg::*;

  sep_word_s  slot [2];
  logic       wr_ptr;
  logic       rd_ptr;
  logic [1:0] count;
  logic       push;
  logic       pop;

  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_word  = slot[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      slot[0] <= '0;
      slot[1] <= '0;
    end else if (push) begin
      slot[wr_ptr] <= in_word;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// file: tb/sep_mst.sv
`timescale 1ns/1ns
`default_nettype none
module sep_mst (
  // link pins
  output logic      scl,
  output logic      pull,
  input  wire logic sda
);
  int gap = 0;
  initial {scl, pull} = 2'b10;
  // data moves mid-low; gap stretches the low phase to stall
  task automatic bit_io(input logic b, output logic r);
    #(20 + gap) pull = ~b;
    #20 scl = 1'b1;
    #20 r = sda;
    #20 scl = 1'b0;
  endtask
  // also a repeated start when scl is low
  task automatic start_c();
    #20 pull = 1'b0;
    #20 scl = 1'b1;
    #20 pull = 1'b1;
    #20 scl = 1'b0;
  endtask
  // scl stands high after this
  task automatic stop_c();
    #20 pull = 1'b1;
    #20 scl = 1'b1;
    #20 pull = 1'b0;
    #20;
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic get(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~ack, r);
  endtask
endmodule
`default_nettype wire

// file: tb/sep_checker.sv
`timescale 1ns/1ns
`default_nettype none
module sep_checker
  import sep_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe
);
  // ----------------
  // bit tracking
  // ----------------
  logic       scl_q, sda_q, first, rd;
  logic [3:0] cnt;
  logic [7:0] sh;
  wire logic  rise = scl & ~scl_q;
  wire logic  go = scl & scl_q & sda_q & ~sda_in;
  wire logic  s9 = rise & (cnt == 4'h8);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {scl_q, sda_q, first, rd, cnt, sh} <= {4'hc, 12'h000};
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
      if (go) begin
        cnt <= 4'h0;
        first <= 1'b1;
      end else if (s9) begin
        cnt <= 4'h0;
        first <= 1'b0;
        rd <= first ? sh[0] : rd;
      end else if (rise) begin
        cnt <= cnt + 4'h1;
        sh <= {sh[6:0], sda_in};
      end
    end
  end
  // ----------------
  // properties
  // ----------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_dev; s9 && first; endsequence
  sequence s_rd; s9 && !first && rd; endsequence
  sequence s_wr; s9 && !first && !rd; endsequence
  property p_type; s_dev |-> sda_oe == (sh[7:4] == DEV_TYPE); endproperty
  a_type: assert property (p_type) else $error("address ack wrong");
  property p_rel; s_rd |-> !sda_oe; endproperty
  a_rel: assert property (p_rel) else $error("read ack slot held");
  property p_nack; s_rd ##0 sda_in |=> !sda_oe [*8]; endproperty
  a_nack: assert property (p_nack) else $error("drive after nack");
  property p_wack; s_wr |-> sda_oe; endproperty
  a_wack: assert property (p_wack) else $error("write byte not acked");
  property p_hold; scl && $past(scl) && $past(scl, 2) |-> $stable(sda_oe); endproperty
  a_hold: assert property (p_hold) else $error("line moved in high");
  property p_late; $changed(sda_oe) |-> !$past(scl, 2); endproperty
  a_late: assert property (p_late) else $error("line moved early");
  property p_od; sda_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("line driven high");
  property p_rst; $rose(rst_n) |-> !sda_oe; endproperty
  a_rst: assert property (p_rst) else $error("line held at reset");
endmodule
bind sep_read_path sep_checker i_sep_checker (.mclk(mclk), .rst_n(rst_n), .scl(scl),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import sep_pkg::*;
  logic       mclk, rst_n;
  wire logic  scl, pull, sda, sda_out, sda_oe;
  logic [7:0] mem [DEPTH];
  logic [10:0] ptr;
  int         err_total, n_checks;
  sep_word_s  rows [5] = '{{11'h7fe, 8'h3c}, {11'h7ff, 8'ha5}, {11'h000, 8'h5a},
                           {11'h001, 8'hc3}, {11'h2a5, 8'h96}};
  // wired-and with pull-up
  assign sda = ~(sda_oe | pull);
  always #5 mclk = ~mclk;
  sep_read_path i_sep_read_path (.mclk(mclk), .rst_n(rst_n), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe));
  sep_mst i_sep_mst (.scl(scl), .pull(pull), .sda(sda));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic send(input logic [7:0] b, input logic exp_ack);
    logic ack;
    i_sep_mst.put(b, ack);
    chk("ack", {7'h00, ack}, {7'h00, exp_ack});
  endtask
  task automatic wr_byte(input sep_word_s w);
    i_sep_mst.start_c();
    send({DEV_TYPE, w.addr[10:8], 1'b0}, 1'b1);
    send(w.addr[7:0], 1'b1);
    send(w.data, 1'b1);
    i_sep_mst.stop_c();
    mem[w.addr] = w.data;
  endtask
  // upper bits of the read byte are inverted on purpose
  task automatic rd_seq(input logic rnd, input logic [10:0] a, input int n, input logic fin);
    logic [7:0] d;
    i_sep_mst.start_c();
    if (rnd) begin
      send({DEV_TYPE, a[10:8], 1'b0}, 1'b1);
      send(a[7:0], 1'b1);
      i_sep_mst.start_c();
      ptr = a;
    end
    send({DEV_TYPE, ~ptr[10:8], DIR_READ}, 1'b1);
    for (int i = 0; i < n; i++) begin
      i_sep_mst.get(i < n - 1, d);
      chk("data", d, mem[ptr]);
      ptr = ptr + 11'h001;
    end
    if (fin) i_sep_mst.stop_c();
  endtask
  initial begin
    #400000;
    err_total++;
    wrap_up();
  end
  initial begin
    {mclk, rst_n, err_total, n_checks} = '0;
    foreach (mem[i]) mem[i] = ERASED;
    repeat (2) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    rd_seq(1'b1, 11'h2a5, 1, 1'b1);
    foreach (rows[i]) wr_byte(rows[i]);
    foreach (rows[i]) rd_seq(1'b1, rows[i].addr, 1, 1'b1);
    rd_seq(1'b0, ptr, 1, 1'b1);
    rd_seq(1'b1, 11'h7fe, 4, 1'b0);
    rd_seq(1'b0, ptr, 2, 1'b1);
    i_sep_mst.gap = 400;
    rd_seq(1'b1, 11'h7ff, 3, 1'b1);
    i_sep_mst.gap = 0;
    i_sep_mst.start_c();
    send({DEV_TYPE ^ 4'h3, 3'h0, DIR_READ}, 1'b0);
    i_sep_mst.stop_c();
    rd_seq(1'b0, ptr, 1, 1'b1);
    @(posedge mclk);
    #1 rst_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge mclk);
    #1 ptr = ADDR_RST;
    rd_seq(1'b0, ptr, 2, 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
